// ===== rtl/ebw_pkg.sv
// package: constants, modes and carrier types of the expansion-bus wait-stretch controller
// How it works
// R1 - wait honoured only chip selects 0..3, async styles and sync-style reads
// R2 - peripheral asserts wait during setup phase
// R3 - idle wait line pulled high externally
// R4 - synchronous-style writes ignore wait entirely
// R5 - wait seen before strobe holds strobe phase
// R6 - wait input synchronised before state machine
// R7 - peripheral asserts wait three cycles early
// R8 - setup phase one to four cycles
// R9 - strobe phase one to sixteen cycles
// R10 - hold phase one to four cycles
// R11 - recovery phase one to sixteen cycles
// R12 - wait line active low
package ebw_pkg;

	// ----------------------------------------
	// bus styles and phases
	// ----------------------------------------
	typedef enum logic [1:0] {
		EBW_STYLE_RDWR_ASYNC = 2'h0,
		EBW_STYLE_RDWR_SYNC = 2'h1,
		EBW_STYLE_SINGLE_DS = 2'h2,
		EBW_STYLE_OTHER = 2'h3
	} ebw_style_t;

	typedef enum logic [2:0] {
		EBW_ST_IDLE = 3'h0,
		EBW_ST_SETUP = 3'h1,
		EBW_ST_STROBE = 3'h2,
		EBW_ST_HOLD = 3'h3,
		EBW_ST_RECOV = 3'h4
	} ebw_state_t;

	// ----------------------------------------
	// widths, limits and timing
	// ----------------------------------------
	localparam int EBW_AW = 24;
	localparam int EBW_DW = 16;
	localparam int EBW_CSW = 3;
	localparam logic [EBW_CSW-1:0] EBW_CS_WAIT_MAX = 3'h3;
	localparam logic [3:0] EBW_CNT_ZERO = 4'h0;
	localparam logic [3:0] EBW_CNT_ONE = 4'h1;
	localparam logic [2:0] EBW_SYNC_RST = 3'h7;
	localparam int EBW_WAIT_LEAD_CYC = 3;
	localparam int EBW_CLK_NS = 50;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic [EBW_CSW-1:0] cs;
		logic write;
		logic [EBW_AW-1:0] addr;
		logic [EBW_DW-1:0] wdata;
		ebw_style_t style;
		logic [1:0] setup_m1;
		logic [3:0] strobe_m1;
		logic [1:0] hold_m1;
		logic [3:0] recov_m1;
	} ebw_req_t;

	typedef struct packed {
		logic cs_n_valid;
		logic [EBW_CSW-1:0] cs;
		logic [EBW_AW-1:0] addr;
		logic [EBW_DW-1:0] wdata;
		logic data_oe;
		logic read_strobe_n;
		logic write_strobe_n;
		logic single_data_strobe_n;
		logic rnw;
	} ebw_pins_t;

endpackage

// ===== rtl/ebw_sync.sv
// three-stage synchroniser with agreement filter for an active-low pin
module ebw_sync
	import ebw_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic pin_n_in,
	output logic level_n_out
);

	typedef struct packed {
		logic [2:0] stg;
		logic level_n;
	} ebw_sync_st_t;

	ebw_sync_st_t cur_ff;
	ebw_sync_st_t nxt_ff;

	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.stg = {cur_ff.stg[1:0], pin_n_in}; // see R6
		if (cur_ff.stg[1] == cur_ff.stg[2]) begin
			nxt_ff.level_n = cur_ff.stg[2];
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			cur_ff <= '{stg: EBW_SYNC_RST, level_n: 1'b1};
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign level_n_out = cur_ff.level_n;

endmodule

// ===== rtl/ebw_ctrl.sv
// expansion-bus access sequencer with peripheral wait stretch
module ebw_ctrl
	import ebw_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic req_valid_in,
	input wire ebw_req_t req_in,
	input wire logic peripheral_stall_n_in,
	input wire logic [EBW_DW-1:0] rdata_in,
	output logic req_ready_out,
	output logic done_out,
	output logic [EBW_DW-1:0] rdata_out,
	output logic stretched_out,
	output ebw_pins_t pins_out
);

	typedef struct packed {
		ebw_state_t state;
		ebw_req_t req;
		logic [3:0] cnt;
		logic wait_armed;
		logic stretched;
		logic ready;
		logic done;
		logic [EBW_DW-1:0] rdata;
		ebw_pins_t pins;
	} ebw_ctrl_st_t;

	ebw_ctrl_st_t cur_ff;
	ebw_ctrl_st_t nxt_ff;
	logic stall_n_sync;

	// ----------------------------------------
	// wait input synchroniser
	// ----------------------------------------
	ebw_sync u_sync (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.pin_n_in(peripheral_stall_n_in),
		.level_n_out(stall_n_sync)
	);

	// wait is honoured for low chip selects in async strobe styles, never sync writes
	function automatic logic wait_allowed(input ebw_req_t r);
		logic ok_style;
		ok_style = (r.style == EBW_STYLE_RDWR_ASYNC) || (r.style == EBW_STYLE_SINGLE_DS)
			|| ((r.style == EBW_STYLE_RDWR_SYNC) && !r.write); // see R4
		return ok_style && (r.cs <= EBW_CS_WAIT_MAX); // see R1
	endfunction

	// pin image for a given phase
	function automatic ebw_pins_t pins_for(input ebw_req_t r, input logic active, input logic strobe);
		ebw_pins_t p;
		p = '0;
		p.read_strobe_n = 1'b1;
		p.write_strobe_n = 1'b1;
		p.single_data_strobe_n = 1'b1;
		p.rnw = 1'b1;
		if (active) begin
			p.cs_n_valid = 1'b1;
			p.cs = r.cs;
			p.addr = r.addr;
			p.wdata = r.write ? r.wdata : '0;
			p.data_oe = r.write;
			p.rnw = !r.write;
			if (strobe) begin
				if (r.style == EBW_STYLE_SINGLE_DS) begin
					p.single_data_strobe_n = 1'b0;
				end else begin
					p.read_strobe_n = r.write;
					p.write_strobe_n = !r.write;
				end
			end
		end
		return p;
	endfunction

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.done = 1'b0;
		case (cur_ff.state)
			EBW_ST_IDLE: begin
				nxt_ff.ready = 1'b1;
				if (req_valid_in && cur_ff.ready) begin
					nxt_ff.ready = 1'b0;
					nxt_ff.req = req_in;
					nxt_ff.state = EBW_ST_SETUP;
					nxt_ff.cnt = {2'h0, req_in.setup_m1}; // see R8
					nxt_ff.stretched = 1'b0;
					nxt_ff.wait_armed = 1'b0;
					nxt_ff.pins = pins_for(req_in, 1'b1, 1'b0);
				end
			end
			EBW_ST_SETUP: begin
				if (cur_ff.cnt == EBW_CNT_ZERO) begin
					nxt_ff.state = EBW_ST_STROBE;
					nxt_ff.cnt = cur_ff.req.strobe_m1; // see R9
					// wait already low before the first strobe cycle arms the stretch
					nxt_ff.wait_armed = wait_allowed(cur_ff.req) && !stall_n_sync; // see R5
					nxt_ff.pins = pins_for(cur_ff.req, 1'b1, 1'b1);
				end else begin
					nxt_ff.cnt = cur_ff.cnt - EBW_CNT_ONE;
				end
			end
			EBW_ST_STROBE: begin
				if (wait_allowed(cur_ff.req) && !stall_n_sync) begin
					nxt_ff.wait_armed = 1'b1; // see R12
				end
				if (cur_ff.cnt != EBW_CNT_ZERO) begin
					nxt_ff.cnt = cur_ff.cnt - EBW_CNT_ONE;
				end else if ((cur_ff.wait_armed || wait_allowed(cur_ff.req)) && !stall_n_sync) begin
					// a wait that clears the synchroniser only at the last strobe cycle still holds it
					nxt_ff.stretched = 1'b1; // see R5
				end else begin
					nxt_ff.state = EBW_ST_HOLD;
					nxt_ff.cnt = {2'h0, cur_ff.req.hold_m1}; // see R10
					nxt_ff.rdata = cur_ff.req.write ? cur_ff.rdata : rdata_in;
					nxt_ff.pins = pins_for(cur_ff.req, 1'b1, 1'b0);
				end
			end
			EBW_ST_HOLD: begin
				if (cur_ff.cnt == EBW_CNT_ZERO) begin
					nxt_ff.state = EBW_ST_RECOV;
					nxt_ff.cnt = cur_ff.req.recov_m1; // see R11
					nxt_ff.pins = pins_for(cur_ff.req, 1'b0, 1'b0);
					nxt_ff.done = 1'b1;
				end else begin
					nxt_ff.cnt = cur_ff.cnt - EBW_CNT_ONE;
				end
			end
			EBW_ST_RECOV: begin
				if (cur_ff.cnt == EBW_CNT_ZERO) begin
					nxt_ff.state = EBW_ST_IDLE;
					nxt_ff.ready = 1'b1;
				end else begin
					nxt_ff.cnt = cur_ff.cnt - EBW_CNT_ONE;
				end
			end
			default: begin
				nxt_ff.state = EBW_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			cur_ff <= '0;
			cur_ff.pins.read_strobe_n <= 1'b1;
			cur_ff.pins.write_strobe_n <= 1'b1;
			cur_ff.pins.single_data_strobe_n <= 1'b1;
			cur_ff.pins.rnw <= 1'b1;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign req_ready_out = cur_ff.ready;
	assign done_out = cur_ff.done;
	assign rdata_out = cur_ff.rdata;
	assign stretched_out = cur_ff.stretched;
	assign pins_out = cur_ff.pins;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [2:0] setup_len;
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || cur_ff.state != EBW_ST_SETUP) begin
			setup_len <= 3'h0;
		end else begin
			setup_len <= setup_len + 3'h1;
		end
	end

	a_sync_write_ignore: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see R4
		(cur_ff.state == EBW_ST_STROBE && cur_ff.req.style == EBW_STYLE_RDWR_SYNC && cur_ff.req.write)
		|-> !cur_ff.stretched) else $error("sync write was stretched");

	a_high_cs_ignore: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see R1
		(cur_ff.state == EBW_ST_STROBE && cur_ff.req.cs > EBW_CS_WAIT_MAX) |-> !cur_ff.wait_armed)
		else $error("wait honoured on high chip select");

	a_strobe_held_wait: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see R5
		(cur_ff.state == EBW_ST_STROBE && cur_ff.cnt == EBW_CNT_ZERO && cur_ff.wait_armed && !stall_n_sync)
		|=> cur_ff.state == EBW_ST_STROBE) else $error("strobe left while wait low");

	a_strobe_release: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see R12
		(cur_ff.state == EBW_ST_STROBE && cur_ff.cnt == EBW_CNT_ZERO && stall_n_sync)
		|=> cur_ff.state == EBW_ST_HOLD) else $error("strobe not released on high wait");

	a_setup_len_max: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see R8
		cur_ff.state == EBW_ST_SETUP |-> setup_len <= 3'h3) else $error("setup phase too long");

	a_strobe_min_len: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see R9
		$rose(cur_ff.state == EBW_ST_STROBE) && cur_ff.req.strobe_m1 == 4'h3
		|-> (cur_ff.state == EBW_ST_STROBE)[*4]) else $error("strobe phase too short");

	a_hold_pins_kept: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see R10
		cur_ff.state == EBW_ST_HOLD |-> cur_ff.pins.cs_n_valid && cur_ff.pins.write_strobe_n
		&& cur_ff.pins.read_strobe_n && cur_ff.pins.single_data_strobe_n) else $error("hold phase pins wrong");

	a_recov_no_accept: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see R11
		$rose(cur_ff.state == EBW_ST_RECOV) |-> !cur_ff.pins.cs_n_valid && !cur_ff.ready && cur_ff.done)
		else $error("recovery skipped");

	a_setup_pins_quiet: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see R8
		cur_ff.state == EBW_ST_SETUP |-> cur_ff.pins.cs_n_valid && cur_ff.pins.read_strobe_n
		&& cur_ff.pins.write_strobe_n && cur_ff.pins.single_data_strobe_n)
		else $error("strobe active in setup phase");

	a_strobe_pins_low: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see R9
		cur_ff.state == EBW_ST_STROBE |-> cur_ff.pins.cs_n_valid && !(cur_ff.pins.read_strobe_n
		&& cur_ff.pins.write_strobe_n && cur_ff.pins.single_data_strobe_n))
		else $error("no strobe in strobe phase");

	a_refused_no_stretch: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see R1
		(cur_ff.state == EBW_ST_HOLD && (cur_ff.req.cs > EBW_CS_WAIT_MAX || cur_ff.req.style == EBW_STYLE_OTHER))
		|-> !cur_ff.stretched) else $error("refused access was stretched");

	a_recov_pins_idle: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see R11
		cur_ff.state == EBW_ST_RECOV |-> !cur_ff.pins.cs_n_valid && cur_ff.pins.read_strobe_n
		&& cur_ff.pins.write_strobe_n && cur_ff.pins.single_data_strobe_n)
		else $error("pins active in recovery");

	a_done_single: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // see R10
		cur_ff.done |=> !cur_ff.done) else $error("done held more than one cycle");

endmodule

// ===== verification/ebw_periph.sv
// slow peripheral model: shared stall line and read data
module ebw_periph import ebw_pkg::*;
(
	input wire logic mclk_in,
	input wire ebw_pins_t pins_in,
	input wire logic slow_in,
	output logic stall_n_out,
	output logic [EBW_DW-1:0] rdata_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] age_ff = 5'h00;
	logic [EBW_DW-1:0] last_ff = 16'h0000;
	logic rd_on;
	assign rd_on = pins_in.cs_n_valid && pins_in.rnw && !(pins_in.read_strobe_n && pins_in.single_data_strobe_n);
	// stale bus shows last cycle's data inverted, so a sample one cycle late cannot match
	assign rdata_out = rd_on ? pins_in.addr[15:0] : ~last_ff;
	// low from the first setup cycle on, well ahead of strobe end; pulled high while deselected
	assign stall_n_out = !(slow_in && pins_in.cs_n_valid && age_ff < 5'h0c);
	always @(posedge mclk_in) begin
		age_ff <= pins_in.cs_n_valid ? age_ff + 5'h01 : 5'h00;
		last_ff <= rdata_out;
	end
endmodule

// ===== verification/ebw_ctrl_tb_top.sv
// testbench of the expansion-bus wait-stretch controller
module ebw_ctrl_tb_top import ebw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic valid = 1'b0;
	logic slow = 1'b0;
	logic ready, done, strd, stall_n;
	ebw_req_t req = '0;
	ebw_pins_t pins;
	logic [EBW_DW-1:0] rdata_bus, rdata;
	int su_n, sb_n, ho_n, error_cnt, cmp_count;
	logic [EBW_CSW-1:0] seen_cs;
	logic [EBW_AW-1:0] seen_addr;
	logic [EBW_DW-1:0] seen_wd;
	logic seen_oe, seen_rnw;
	wire strobe_low = !(pins.read_strobe_n && pins.write_strobe_n && pins.single_data_strobe_n);
	initial forever #25 mclk_in = ~mclk_in;
	ebw_ctrl ebw_ctrl_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .req_valid_in(valid), .req_in(req),
		.peripheral_stall_n_in(stall_n), .rdata_in(rdata_bus), .req_ready_out(ready), .done_out(done),
		.rdata_out(rdata), .stretched_out(strd), .pins_out(pins));
	ebw_periph ebw_periph_inst (.mclk_in(mclk_in), .pins_in(pins), .slow_in(slow), .stall_n_out(stall_n),
		.rdata_out(rdata_bus));
	// phase lengths measured on the pins of each access
	always @(posedge mclk_in) begin
		if (pins.cs_n_valid !== 1'b1) begin
			su_n <= 0;
			sb_n <= 0;
			ho_n <= 0;
		end else if (strobe_low) begin
			sb_n <= sb_n + 1;
			seen_cs <= pins.cs;
			seen_addr <= pins.addr;
			seen_wd <= pins.wdata;
			seen_oe <= pins.data_oe;
			seen_rnw <= pins.rnw;
		end else if (sb_n == 0) begin
			su_n <= su_n + 1;
		end else begin
			ho_n <= ho_n + 1;
		end
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic access(logic [2:0] cs, logic wr, ebw_style_t st, logic [1:0] su, logic [3:0] sb,
		logic [1:0] ho, logic [3:0] rc, logic sl, logic ex);
		int n;
		logic [EBW_AW-1:0] a;
		logic [EBW_DW-1:0] wd;
		a = {8'h00, 13'h0a5a, cs};
		wd = ~a[15:0];
		n = 0;
		@(negedge mclk_in);
		while (ready !== 1'b1 && n < 200) begin
			@(negedge mclk_in);
			n++;
		end
		chk("ready before request", 1, ready);
		@(posedge mclk_in);
		valid <= 1'b1;
		slow <= sl;
		req <= '{cs: cs, write: wr, addr: a, wdata: ~a[15:0], style: st, setup_m1: su, strobe_m1: sb,
			hold_m1: ho, recov_m1: rc};
		@(posedge mclk_in);
		valid <= 1'b0;
		n = 0;
		do begin
			@(negedge mclk_in);
			n++;
		end while (done !== 1'b1 && n < 200);
		chk("done pulse", 1, done);
		chk("setup cycles", su + 1, su_n);
		chk("chip select", cs, seen_cs);
		chk("strobe address", a, seen_addr);
		chk("data drive", wr, seen_oe);
		chk("read not write", !wr, seen_rnw);
		if (wr) chk("write data", wd, seen_wd);
		chk("hold cycles", ho + 1, ho_n);
		chk("stretched", ex, strd);
		if (ex) chk("strobe extended", 1, sb_n > sb + 1);
		else chk("strobe cycles", sb + 1, sb_n);
		if (!wr) chk("read data", a[15:0], rdata);
		n = 0;
		while (ready !== 1'b1 && n < 40) begin
			@(negedge mclk_in);
			n++;
		end
		chk("recovery cycles", rc + 1, n);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#(EBW_CLK_NS * 2000);
		error_cnt++;
		end_of_test();
	end
	initial begin
		repeat (4) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		access(3'h0, 1'b0, EBW_STYLE_RDWR_ASYNC, 2'h0, 4'h0, 2'h0, 4'h0, 1'b0, 1'b0);
		access(3'h1, 1'b0, EBW_STYLE_RDWR_ASYNC, 2'h0, 4'h3, 2'h1, 4'h2, 1'b1, 1'b1);
		access(3'h2, 1'b1, EBW_STYLE_RDWR_SYNC, 2'h0, 4'h3, 2'h0, 4'h0, 1'b1, 1'b0);
		access(3'h3, 1'b0, EBW_STYLE_RDWR_SYNC, 2'h1, 4'h3, 2'h0, 4'h1, 1'b1, 1'b1);
		access(3'h4, 1'b0, EBW_STYLE_RDWR_ASYNC, 2'h0, 4'h3, 2'h0, 4'h0, 1'b1, 1'b0);
		access(3'h3, 1'b1, EBW_STYLE_SINGLE_DS, 2'h0, 4'h3, 2'h2, 4'h1, 1'b1, 1'b1);
		access(3'h0, 1'b0, EBW_STYLE_OTHER, 2'h0, 4'h3, 2'h0, 4'h0, 1'b1, 1'b0);
		access(3'h1, 1'b1, EBW_STYLE_RDWR_ASYNC, 2'h3, 4'hf, 2'h3, 4'hf, 1'b0, 1'b0);
		end_of_test();
	end
endmodule
